// file: logic/fsr_pkg.sv
// Constants for the full-frame sensor readout controller.
// Assumes a single 50 MHz clock; all sensor clocks are derived from it.
package fsr_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    // Array geometry
    localparam int unsigned LINES = 4097;
    localparam int unsigned PIXELS = 4096;
    localparam logic [12:0] LINE_LAST = 13'(LINES - 1);
    localparam logic [11:0] PIX_LAST = 12'(PIXELS - 1);
    // Light-sensitive window, 4080 columns by 4081 rows, centred in the array
    localparam logic [11:0] ACT_COL_FIRST = 12'h008;
    localparam logic [11:0] ACT_COL_LAST = 12'hFF7;
    localparam logic [12:0] ACT_ROW_FIRST = 13'h0008;
    localparam logic [12:0] ACT_ROW_LAST = 13'h0FF8;
    // Pixel period 200 ns (5 MHz, inside the 10 MHz horizontal limit)
    localparam int unsigned PIX_NS = 200;
    localparam int unsigned PIX_CYC = PIX_NS * (CLK_HZ / 1_000_000) / 1000;
    localparam int unsigned HPH_CYC = PIX_CYC / 3;
    localparam logic [3:0] STEP_LAST = 4'(PIX_CYC - 1);
    localparam logic [3:0] STEP_PH_B = 4'(HPH_CYC);
    localparam logic [3:0] STEP_PH_C = 4'(2 * HPH_CYC);
    localparam logic [3:0] STEP_PH_END = 4'(3 * HPH_CYC);
    // Output reset pulse of 40 ns at the start of a pixel
    localparam int unsigned RST_NS = 40;
    localparam logic [3:0] STEP_RST_END = 4'((RST_NS * (CLK_HZ / 1_000_000) + 999) / 1000);
    // Video is sampled well after the summing gate falls at STEP_PH_B
    localparam logic [3:0] STEP_SAMPLE = 4'h7;
    // Vertical phase dwell 1 us
    localparam int unsigned VPH_NS = 1000;
    localparam logic [31:0] VPH_CYC = 32'(VPH_NS * (CLK_HZ / 1_000_000) / 1000);
    localparam int unsigned VIDEO_W = 16;
    localparam int unsigned WORD_W = VIDEO_W + 3;
    typedef enum logic [2:0] {FSR_IDLE, FSR_INTEG, FSR_VSHIFT, FSR_HSHIFT} fsr_state_t;
endpackage

// file: logic/fsr_skid.sv
// Two-entry skid buffer between the sampler and the pixel consumer.
// Assumes the producer pushes only while o_ready is high.
module fsr_skid #(
    parameter int unsigned WIDTH = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    logic spare_valid;
    logic [WIDTH-1:0] spare_data;
    logic take;
    logic push;
    logic next_spare_valid;

    assign take = o_valid && i_ready;
    assign push = i_valid && o_ready;

    always_comb begin
        next_spare_valid = spare_valid;
        if (spare_valid && (!o_valid || take)) begin
            next_spare_valid = 1'b0;
        end else if (push && o_valid && !take) begin
            next_spare_valid = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_valid <= 1'b0;
            o_data <= '0;
        end else if (!o_valid || take) begin
            if (spare_valid) begin
                o_valid <= 1'b1;
                o_data <= spare_data;
            end else begin
                o_valid <= push;
                if (push) begin
                    o_data <= i_data;
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            spare_valid <= 1'b0;
            spare_data <= '0;
            o_ready <= 1'b0;
        end else begin
            spare_valid <= next_spare_valid;
            o_ready <= !next_spare_valid;
            if (push && o_valid && !take) begin
                spare_data <= i_data;
            end
        end
    end

    // A stalled word must stay put until taken
    a_out_held: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_valid && !i_ready |=> o_valid && $stable(o_data))
        else $error("Stalled output word changed");

    a_no_overrun: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        spare_valid |-> !o_ready)
        else $error("Buffer ready while full");
endmodule // fsr_skid

// file: logic/fsr_ctrl.sv
// Readout timing generator for a three-phase full-frame image array.
// Drives vertical, transfer, horizontal, summing and reset clocks and a shutter;
// assumes level shifters outside and an ADC whose word arrives on i_video.

// Function
// - A frame is 4097 lines of 4096 pixels each, in order.
// - After integration, cycle the three vertical phases to move rows down.
// - Keep the shutter closed for the whole readout.
// - Each of the four quadrants may be clocked independently.
// - The whole array can be read through any one output amplifier.
// - Summing gate follows horizontal phase one unless binning pixels.
// - Sample video only after the summing gate falls.
// - Pulse output reset before each packet, but not while binning.
// - Pinned low-dark mode holds every vertical clock low while integrating.
// - Buried-channel mode holds phase one of every group high while integrating.
// - Vertical phases form four groups A to D, twelve lines in all.
module fsr_ctrl (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire logic [31:0] i_exposure_cycles,
    input wire logic i_pinned_low_dark_mode,
    input wire logic [1:0] i_amp_sel,
    input wire logic [3:0] i_group_hold,
    input wire logic [2:0] i_bin_len,
    input wire logic [15:0] i_video,
    output logic [11:0] o_vclk,
    output logic o_line_transfer_gate_clock,
    output logic [2:0] o_hclk,
    output logic o_summing_gate_clock,
    output logic o_reset_clock,
    output logic o_shutter_open,
    output logic o_busy,
    output logic o_frame_done,
    output logic o_pix_valid,
    input wire logic i_pix_ready,
    output logic [15:0] o_pix_data,
    output logic o_pix_sof,
    output logic o_pix_sol,
    output logic o_pix_active
);
    fsr_pkg::fsr_state_t state;
    logic [31:0] timer;
    logic [1:0] vph;
    logic [3:0] step;
    logic [12:0] line;
    logic [11:0] pix;
    logic [2:0] bin_cnt;
    logic [2:0] bin_len;
    logic pinned_low_dark_mode;
    logic [1:0] amp;
    logic [3:0] hold;
    logic [15:0] vid_s1;
    logic [15:0] vid_s2;
    logic buf_ready;
    logic last_of_bin;
    logic at_sample;
    logic push;
    logic [fsr_pkg::WORD_W-1:0] word;
    logic [fsr_pkg::WORD_W-1:0] buf_out;
    logic [2:0] rest_v;
    logic [2:0] shift_v;
    logic [11:0] next_vclk;
    logic next_vtg;
    logic [2:0] next_hclk;
    logic next_sg;
    logic next_rst;
    logic sg_fell_pending;

    assign last_of_bin = (bin_cnt == bin_len - 3'h1);
    assign at_sample = (state == fsr_pkg::FSR_HSHIFT) && (step == fsr_pkg::STEP_SAMPLE);
    assign push = at_sample && last_of_bin && buf_ready;

    // Video pins are asynchronous to i_clk
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            vid_s1 <= 16'h0000;
            vid_s2 <= 16'h0000;
        end else begin
            vid_s1 <= i_video;
            vid_s2 <= vid_s1;
        end
    end

    // Configuration is frozen for the frame so a change cannot tear it
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pinned_low_dark_mode <= 1'b1;
            amp <= 2'h0;
            hold <= 4'h0;
            bin_len <= 3'h1;
        end else if (state == fsr_pkg::FSR_IDLE && i_start) begin
            pinned_low_dark_mode <= i_pinned_low_dark_mode;
            amp <= i_amp_sel;
            hold <= i_group_hold;
            bin_len <= (i_bin_len == 3'h0) ? 3'h1 : i_bin_len;
        end
    end

    // Sequencer with line and pixel counters
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= fsr_pkg::FSR_IDLE;
            timer <= 32'h0000_0000;
            vph <= 2'h0;
            step <= 4'h0;
            line <= 13'h0000;
            pix <= 12'h000;
            bin_cnt <= 3'h0;
            o_frame_done <= 1'b0;
        end else begin
            o_frame_done <= 1'b0;
            unique case (state)
                fsr_pkg::FSR_IDLE: begin
                    if (i_start) begin
                        state <= fsr_pkg::FSR_INTEG;
                        timer <= 32'h0000_0000;
                        line <= 13'h0000;
                    end
                end
                fsr_pkg::FSR_INTEG: begin
                    timer <= timer + 32'h0000_0001;
                    if (timer + 32'h0000_0001 >= i_exposure_cycles) begin
                        state <= fsr_pkg::FSR_VSHIFT;
                        timer <= 32'h0000_0000;
                        vph <= 2'h0;
                    end
                end
                fsr_pkg::FSR_VSHIFT: begin
                    timer <= timer + 32'h0000_0001;
                    if (timer == fsr_pkg::VPH_CYC - 32'h0000_0001) begin
                        timer <= 32'h0000_0000;
                        vph <= vph + 2'h1;
                        if (vph == 2'h2) begin
                            state <= fsr_pkg::FSR_HSHIFT;
                            // Keeps the phase index inside the three-bit pattern
                            vph <= 2'h0;
                            step <= 4'h0;
                            pix <= 12'h000;
                            bin_cnt <= 3'h0;
                        end
                    end
                end
                // one horizontal cycle per pixel, counts
                fsr_pkg::FSR_HSHIFT: begin
                    if (!(at_sample && last_of_bin && !buf_ready)) begin
                        step <= (step == fsr_pkg::STEP_LAST) ? 4'h0 : step + 4'h1;
                    end
                    if (step == fsr_pkg::STEP_LAST) begin
                        pix <= pix + 12'h001;
                        bin_cnt <= last_of_bin ? 3'h0 : bin_cnt + 3'h1;
                        if (pix == fsr_pkg::PIX_LAST) begin
                            line <= line + 13'h0001;
                            if (line == fsr_pkg::LINE_LAST) begin
                                state <= fsr_pkg::FSR_IDLE;
                                o_frame_done <= 1'b1;
                            end else begin
                                state <= fsr_pkg::FSR_VSHIFT;
                                timer <= 32'h0000_0000;
                                vph <= 2'h0;
                            end
                        end
                    end
                end
            endcase
        end
    end

    // Clock pattern for the next cycle
    always_comb begin
        // all low when pinned, phase one high otherwise
        rest_v = pinned_low_dark_mode ? 3'h0 : 3'h1;
        // lower amplifiers take the vertical order reversed
        shift_v = 3'h0;
        shift_v[amp[1] ? 2'h2 - vph : vph] = 1'b1;
        next_vclk = 12'h000;
        next_vtg = 1'b1;
        next_hclk = 3'h0;
        next_sg = 1'b0;
        next_rst = 1'b0;
        // four groups, each may be held at rest on its own
        for (int g = 0; g < 4; g++) begin
            next_vclk[3*g +: 3] = (state == fsr_pkg::FSR_VSHIFT && !hold[g]) ? shift_v : rest_v;
        end
        // transfer gate drops during the final vertical phase
        if (state == fsr_pkg::FSR_VSHIFT && vph == 2'h2) begin
            next_vtg = 1'b0;
        end
        if (state == fsr_pkg::FSR_HSHIFT) begin
            // right-hand amplifiers run H1, H3, H2
            if (step < fsr_pkg::STEP_PH_B) begin
                next_hclk = 3'b001;
            end else if (step < fsr_pkg::STEP_PH_C) begin
                next_hclk = amp[0] ? 3'b100 : 3'b010;
            end else if (step < fsr_pkg::STEP_PH_END) begin
                next_hclk = amp[0] ? 3'b010 : 3'b100;
            end
            // follows H1, or stays high to sum a bin
            next_sg = (step < fsr_pkg::STEP_PH_B) || !last_of_bin;
            // reset only at the first pixel of a bin
            next_rst = (bin_cnt == 3'h0) && (step < fsr_pkg::STEP_RST_END);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_vclk <= 12'h000;
            o_line_transfer_gate_clock <= 1'b1;
            o_hclk <= 3'h0;
            o_summing_gate_clock <= 1'b0;
            o_reset_clock <= 1'b0;
            o_shutter_open <= 1'b0;
            o_busy <= 1'b0;
        end else begin
            o_vclk <= next_vclk;
            o_line_transfer_gate_clock <= next_vtg;
            o_hclk <= next_hclk;
            o_summing_gate_clock <= next_sg;
            o_reset_clock <= next_rst;
            o_shutter_open <= (state == fsr_pkg::FSR_INTEG);
            o_busy <= (state != fsr_pkg::FSR_IDLE);
        end
    end

    // frame and line marks, active-area flag travel with each sample
    assign word = {line == 13'h0000 && pix < 12'(bin_len),
                   pix < 12'(bin_len),
                   line >= fsr_pkg::ACT_ROW_FIRST && line <= fsr_pkg::ACT_ROW_LAST &&
                   pix >= fsr_pkg::ACT_COL_FIRST && pix <= fsr_pkg::ACT_COL_LAST,
                   vid_s2};

    fsr_skid #(.WIDTH(fsr_pkg::WORD_W)) u_skid (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_valid(push),
        .o_ready(buf_ready),
        .i_data(word),
        .o_valid(o_pix_valid),
        .i_ready(i_pix_ready),
        .o_data(buf_out)
    );

    assign o_pix_data = buf_out[15:0];
    assign o_pix_active = buf_out[16];
    assign o_pix_sol = buf_out[17];
    assign o_pix_sof = buf_out[18];

    // Helper: a summing-gate fall not yet consumed by a sample
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sg_fell_pending <= 1'b0;
        end else if ($fell(o_summing_gate_clock)) begin
            sg_fell_pending <= 1'b1;
        end else if (push) begin
            sg_fell_pending <= 1'b0;
        end
    end

    a_shutter_shut: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        state == fsr_pkg::FSR_VSHIFT || state == fsr_pkg::FSR_HSHIFT |=> !o_shutter_open)
        else $error("Shutter open during readout");
    a_pinned_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        state == fsr_pkg::FSR_INTEG && pinned_low_dark_mode |=> o_vclk == 12'h000)
        else $error("Vertical clock high in pinned integration");
    a_buried_high: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        state == fsr_pkg::FSR_INTEG && !pinned_low_dark_mode |=> o_vclk == 12'h249)
        else $error("Phase one not held high in buried mode");
    a_sample_after: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        push |-> sg_fell_pending && !o_summing_gate_clock)
        else $error("Video sampled before summing gate fell");
    a_sg_follows: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $past(state) == fsr_pkg::FSR_HSHIFT && bin_len == 3'h1 |-> o_summing_gate_clock == o_hclk[0])
        else $error("Summing gate does not follow phase one");
    a_no_bin_reset: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        state == fsr_pkg::FSR_HSHIFT && bin_cnt != 3'h0 |=> !o_reset_clock)
        else $error("Reset pulsed inside a bin");
    a_vtg_window: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $fell(o_line_transfer_gate_clock) |-> ($past(vph) == 2'h2)[*1] ##0 !o_hclk[0])
        else $error("Transfer gate low outside last vertical phase");
    a_line_end: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        state == fsr_pkg::FSR_HSHIFT && step == fsr_pkg::STEP_LAST && pix == fsr_pkg::PIX_LAST &&
        line == fsr_pkg::LINE_LAST |=> state == fsr_pkg::FSR_IDLE && o_frame_done ##1 !o_frame_done)
        else $error("Frame did not end after the last line");
endmodule // fsr_ctrl

// file: sim/fsr_sensor_model.sv
// Behavioural model of the full-frame image array behind the readout controller.
// Assumes the controller's registered clocks; video carries a column-coded level per packet.
module fsr_sensor_model (
    input wire logic i_line_transfer_gate_clock,
    input wire logic [2:0] i_hclk,
    input wire logic i_summing_gate_clock,
    input wire logic i_reset_clock,
    input wire logic i_shutter_open,
    output logic [15:0] o_video
);
    timeunit 1ns;
    timeprecision 1ps;
    int row_n = -1;
    int site = 0;
    logic [15:0] sg_charge = 16'h0000;
    logic [15:0] node = 16'h0000;
    logic h1_q = 1'b0;
    logic sg_q = 1'b0;
    logic rst_q = 1'b0;
    logic vtg_q = 1'b1;
    logic sh_q = 1'b0;
    initial o_video = 16'h5A5A;
    function automatic logic [15:0] charge(int row, int col);
        if (row >= int'(fsr_pkg::ACT_ROW_FIRST) && row <= int'(fsr_pkg::ACT_ROW_LAST) &&
            col >= int'(fsr_pkg::ACT_COL_FIRST) && col <= int'(fsr_pkg::ACT_COL_LAST)) begin
            return 16'h8000 | 16'(col);
        end
        return 16'(col);
    endfunction
    // Edges are tracked in one process so that simultaneous H1 and gate falls keep their order
    always @(i_hclk, i_summing_gate_clock, i_reset_clock, i_line_transfer_gate_clock,
             i_shutter_open) begin
        if (i_shutter_open === 1'b1 && sh_q === 1'b0) begin
            row_n = -1;
        end
        if (vtg_q === 1'b1 && i_line_transfer_gate_clock === 1'b0) begin
            row_n++;
            site = 0;
        end
        if (h1_q === 1'b1 && i_hclk[0] === 1'b0) begin
            sg_charge = sg_charge + charge(row_n, (i_hclk[2] === 1'b1) ? 4095 - site : site);
            site++;
        end
        if (sg_q === 1'b1 && i_summing_gate_clock === 1'b0) begin
            node = node + sg_charge;
            sg_charge = 16'h0000;
            o_video = node;
        end
        if (rst_q === 1'b0 && i_reset_clock === 1'b1) begin
            node = 16'h0000;
            o_video = ~o_video;
        end
        h1_q = i_hclk[0];
        sg_q = i_summing_gate_clock;
        rst_q = i_reset_clock;
        vtg_q = i_line_transfer_gate_clock;
        sh_q = i_shutter_open;
    end
endmodule // fsr_sensor_model

// file: sim/fullframe_sensor_readout_tb.sv
// Self-checking bench for the full-frame readout controller.
// Assumes the sensor model on i_video; only the first words of each frame are checked.
module fullframe_sensor_readout_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WORDS = 20;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_start = 1'b0;
    logic [31:0] i_exposure_cycles = 32'h00000004;
    logic i_pinned_low_dark_mode = 1'b1;
    logic [1:0] i_amp_sel = 2'h0;
    logic [3:0] i_group_hold = 4'h0;
    logic [2:0] i_bin_len = 3'h1;
    logic i_pix_ready = 1'b0;
    logic [15:0] video;
    logic [11:0] o_vclk;
    logic o_vtg, o_sg, o_reset_clock, o_shutter_open, o_busy, o_pix_valid;
    logic o_frame_done;
    logic o_pix_sof, o_pix_sol, o_pix_active;
    logic [2:0] o_hclk;
    logic [15:0] o_pix_data;
    int failures = 0;
    int n_checks = 0;
    int rst_seen = 0;
    int h1_seen = 0;
    int bin_now = 1;
    logic [18:0] exp_q[$];

    initial forever #10 i_clk = ~i_clk;

    fsr_ctrl i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_start(i_start),
        .i_exposure_cycles(i_exposure_cycles), .i_pinned_low_dark_mode(i_pinned_low_dark_mode),
        .i_amp_sel(i_amp_sel), .i_group_hold(i_group_hold), .i_bin_len(i_bin_len),
        .i_video(video), .o_vclk(o_vclk), .o_line_transfer_gate_clock(o_vtg), .o_hclk(o_hclk),
        .o_summing_gate_clock(o_sg), .o_reset_clock(o_reset_clock),
        .o_shutter_open(o_shutter_open), .o_busy(o_busy), .o_frame_done(o_frame_done),
        .o_pix_valid(o_pix_valid), .i_pix_ready(i_pix_ready), .o_pix_data(o_pix_data),
        .o_pix_sof(o_pix_sof), .o_pix_sol(o_pix_sol), .o_pix_active(o_pix_active));

    fsr_sensor_model i_sensor (.i_line_transfer_gate_clock(o_vtg), .i_hclk(o_hclk),
        .i_summing_gate_clock(o_sg), .i_reset_clock(o_reset_clock),
        .i_shutter_open(o_shutter_open), .o_video(video));

    task automatic check(input logic [18:0] got, input logic [18:0] want);
        n_checks++;
        if (got !== want) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask

    task automatic results();
        if (failures == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    function automatic logic [11:0] vexp(int p, logic pinned_low_dark_mode, logic [3:0] hold, logic rev);
        logic [11:0] v;
        v = 12'h000;
        for (int g = 0; g < 4; g++) begin
            if (hold[g]) v[3 * g] = !pinned_low_dark_mode;
            else v[3 * g + (rev ? 2 - p : p)] = 1'b1;
        end
        return v;
    endfunction

    always @(posedge i_clk) begin
        if (o_pix_valid === 1'b1 && i_pix_ready === 1'b1 && exp_q.size() > 0) begin
            check({o_pix_sof, o_pix_sol, o_pix_active, o_pix_data}, exp_q.pop_front());
        end
    end

    always @(posedge o_reset_clock) rst_seen++;
    always @(posedge o_hclk[0]) h1_seen++;
    always @(negedge o_sg) begin
        if (i_rst_n === 1'b1) begin
            check(19'(o_shutter_open), 19'h00000);
            check(19'(rst_seen), 19'h00001);
            check(19'(h1_seen), 19'(bin_now));
            rst_seen = 0;
            h1_seen = 0;
        end
    end

    task automatic run(input logic pinned_low_dark_mode, input logic [1:0] amp, input logic [2:0] bin);
        int col;
        int n;
        logic [15:0] sum;
        bin_now = (bin == 3'h0) ? 1 : int'(bin);
        for (int j = 0; j < WORDS; j++) begin
            sum = 16'h0000;
            for (int i = 0; i < bin_now; i++) begin
                col = j * bin_now + i;
                sum = sum + 16'(amp[0] ? 4095 - col : col);
            end
            exp_q.push_back({j == 0, j == 0, 1'b0, sum});
        end
        i_pinned_low_dark_mode = pinned_low_dark_mode;
        i_amp_sel = amp;
        i_bin_len = bin;
        i_group_hold = 4'($urandom());
        i_exposure_cycles = 32'($urandom_range(9, 2));
        rst_seen = 0;
        h1_seen = 0;
        i_start = 1'b1;
        @(negedge i_clk);
        i_start = 1'b0;
        // Busy and shutter follow one edge after the start is taken
        check(19'({o_frame_done, o_busy, o_shutter_open}), 19'h00000);
        @(negedge i_clk);
        check(19'({o_frame_done, o_busy, o_shutter_open}), 19'h00003);
        check(19'(o_vclk), 19'(pinned_low_dark_mode ? 12'h000 : 12'h249));
        n = 0;
        while (o_shutter_open === 1'b1 && n < 100) begin
            @(negedge i_clk);
            n++;
        end
        check(19'(n), 19'(i_exposure_cycles));
        for (int p = 0; p < 3; p++) begin
            repeat ((p == 0) ? 25 : 50) @(negedge i_clk);
            check(19'(o_vclk), 19'(vexp(p, pinned_low_dark_mode, i_group_hold, amp[1])));
            check(19'(o_vtg), 19'((p == 2) ? 0 : 1));
        end
        n = 0;
        while (exp_q.size() > 0 && n < 20000) begin
            @(negedge i_clk);
            i_pix_ready = ($urandom_range(3, 0) != 0) && !(n >= 40 && n < 140);
            n++;
        end
        check(19'(exp_q.size()), 19'h00000);
        @(negedge i_clk);
        i_rst_n = 1'b0;
        i_pix_ready = 1'b0;
        repeat (3) @(negedge i_clk);
        i_rst_n = 1'b1;
    endtask

    initial begin
        void'($urandom(32'h9C709E13));
        repeat (12) @(negedge i_clk);
        i_rst_n = 1'b1;
        run(1'b1, 2'h0, 3'h1);
        run(1'b0, 2'h3, 3'h1);
        run(1'b1, 2'h1, 3'h3);
        run(1'b0, 2'h2, 3'h0);
        run(1'b1, 2'h0, 3'h7);
        results();
    end

    // The five frame slices need about 4000 cycles; this leaves ample margin
    initial begin
        repeat (60000) @(posedge i_clk);
        failures++;
        results();
    end
endmodule // fullframe_sensor_readout_tb
